// File: hw/qpw_regs.vh
// Constants for the quad potentiometer wiper register bank
`ifndef QPW_REGS_VH
`define QPW_REGS_VH

// ----------------------------------------------------------------
// Bus address
// ----------------------------------------------------------------
// Type value whose bits 2:0 form the upper three bits of the slave address (arbitrary value)
`define QPW_DEV_TYPE 4'h5

// ----------------------------------------------------------------
// Register geometry
// ----------------------------------------------------------------
`define QPW_CODE_W 6
`define QPW_POTS 4
`define QPW_SLOTS 4
`define QPW_TAPS 64
`define QPW_RECALL_SLOT 2'h0
`define QPW_SAVED_RESET 6'h20
`define QPW_BYTE_BITS 4'h8

// ----------------------------------------------------------------
// Command byte fields and operations
// ----------------------------------------------------------------
`define QPW_CMD_OP_HI 7
`define QPW_CMD_OP_LO 6
`define QPW_CMD_POT_HI 5
`define QPW_CMD_POT_LO 4
`define QPW_CMD_SLOT_HI 3
`define QPW_CMD_SLOT_LO 2
`define QPW_OP_WIPER 2'h0
`define QPW_OP_SAVED 2'h1
`define QPW_OP_RECALL 2'h2
`define QPW_OP_STORE 2'h3

`endif

// File: hw/qpw_sync.v
// Two-stage synchroniser with edge detection on the settled copy
`default_nettype none

module qpw_sync #(
    parameter WIDTH = 6
) (
    input wire i_clk,
    input wire i_nrst,
    input wire [WIDTH-1:0] i_async,
    output reg [WIDTH-1:0] o_level,
    output wire [WIDTH-1:0] o_rise,
    output wire [WIDTH-1:0] o_fall
);

    reg [WIDTH-1:0] meta_reg;
    reg [WIDTH-1:0] prev_reg;

    // ----------------------------------------------------------------
    // Capture chain
    // ----------------------------------------------------------------
    always @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            meta_reg <= {WIDTH{1'b1}};
            o_level <= {WIDTH{1'b1}};
            prev_reg <= {WIDTH{1'b1}};
        end else begin
            meta_reg <= i_async;
            o_level <= meta_reg;
            prev_reg <= o_level;
        end
    end

    assign o_rise = o_level & ~prev_reg;
    assign o_fall = ~o_level & prev_reg;

endmodule // qpw_sync

`default_nettype wire

// File: hw/qpw_tap_decode.v
// Registered one-hot tap switch decode for every potentiometer
`default_nettype none
`include "qpw_regs.vh"

module qpw_tap_decode #(
    parameter POTS = 4,
    parameter CODE_W = 6,
    parameter TAPS = 64
) (
    input wire i_clk,
    input wire i_nrst,
    input wire [POTS*CODE_W-1:0] i_codes,
    output reg [POTS*TAPS-1:0] o_taps
);

    function [TAPS-1:0] one_hot;
        input [CODE_W-1:0] code;
        begin
            one_hot = {{(TAPS-1){1'b0}}, 1'b1} << code;
        end
    endfunction

    // ----------------------------------------------------------------
    // One switch closed per potentiometer
    // ----------------------------------------------------------------
    genvar p;
    generate
        for (p = 0; p < POTS; p = p + 1) begin : g_pot
            always @(posedge i_clk or negedge i_nrst) begin
                if (!i_nrst) begin
                    o_taps[p*TAPS +: TAPS] <= {{(TAPS-1){1'b0}}, 1'b1};
                end else begin
                    o_taps[p*TAPS +: TAPS] <= one_hot(i_codes[p*CODE_W +: CODE_W]);
                end
            end
        end
    endgenerate

endmodule // qpw_tap_decode

`default_nettype wire

// File: hw/qpw_top.v
// Quad potentiometer wiper registers behind a two-wire serial slave
// Behaviour
// - Separate 6-bit wiper register per potentiometer
// - Four 6-bit saved settings per wiper
// - Power-up copies slot zero into each wiper
// - 64 taps, each code selects one
// - Register writes only through serial bus transactions
// - All transfers timed on master serial clock
// - Data line open drain: pull low or release
// - Four address pins, bit0 least significant
// - Respond only when slave address matches pins
// - Exactly one tap connected per wiper
// - Read, write, and copy between wiper, saved
`default_nettype none
`include "qpw_regs.vh"

module qpw_top #(
    parameter [3:0] DEV_TYPE = `QPW_DEV_TYPE,
    parameter [5:0] SAVED_RESET = `QPW_SAVED_RESET
) (
    input wire i_clk,
    input wire i_nrst,
    input wire i_scl,
    input wire i_sda_i,
    output reg o_sda_o,
    output reg o_sda_oe,
    input wire i_addr_pin_bit0,
    input wire i_addr_pin_bit1,
    input wire i_addr_pin_bit2,
    input wire i_addr_pin_bit3,
    output reg [23:0] o_wiper_tap_select,
    output wire [255:0] o_tap_switch,
    output reg o_busy
);

    // ----------------------------------------------------------------
    // States
    // ----------------------------------------------------------------
    localparam [3:0] ST_IDLE = 4'h0;
    localparam [3:0] ST_ADDR = 4'h1;
    localparam [3:0] ST_AACK = 4'h2;
    localparam [3:0] ST_CMD = 4'h3;
    localparam [3:0] ST_CACK = 4'h4;
    localparam [3:0] ST_DATA = 4'h5;
    localparam [3:0] ST_DACK = 4'h6;
    localparam [3:0] ST_READ = 4'h7;
    localparam [3:0] ST_RACK = 4'h8;
    localparam [3:0] ST_IGNORE = 4'h9;

    // Bits in one byte on the bus
    localparam [3:0] BYTE_BITS = `QPW_BYTE_BITS;

    // ----------------------------------------------------------------
    // Decode helpers
    // ----------------------------------------------------------------
    // Flat index of one saved setting
    function [3:0] slot_index;
        input [1:0] pot;
        input [1:0] slot;
        begin
            slot_index = {pot, slot};
        end
    endfunction

    // Addressed transaction in progress
    function in_frame;
        input [3:0] st;
        begin
            in_frame = (st != ST_IDLE) && (st != ST_IGNORE);
        end
    endfunction

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    wire [5:0] pin_level;
    wire [5:0] pin_rise;
    wire [5:0] pin_fall;

    qpw_sync #(
        .WIDTH(6)
    ) u_sync (
        .i_clk(i_clk),
        .i_nrst(i_nrst),
        .i_async({i_addr_pin_bit3, i_addr_pin_bit2, i_addr_pin_bit1, i_addr_pin_bit0,
                  i_sda_i, i_scl}),
        .o_level(pin_level),
        .o_rise(pin_rise),
        .o_fall(pin_fall)
    );

    wire scl_high = pin_level[0];
    wire sda_in = pin_level[1];
    wire scl_rise = pin_rise[0];
    wire scl_fall = pin_fall[0];
    wire [3:0] addr_pins = pin_level[5:2];
    wire bus_start = scl_high & pin_fall[1];
    wire bus_stop = scl_high & pin_rise[1];

    // ----------------------------------------------------------------
    // Storage
    // ----------------------------------------------------------------
    reg [5:0] wiper_mem [0:3];
    reg [5:0] saved_mem [0:15];
    reg recall_pend_reg;

    // ----------------------------------------------------------------
    // Transaction state
    // ----------------------------------------------------------------
    reg [3:0] st_reg;
    reg [3:0] bits_reg;
    reg [7:0] shift_reg;
    reg [7:0] cmd_reg;
    reg rw_reg;
    reg mack_reg;

    wire [1:0] cmd_op = cmd_reg[`QPW_CMD_OP_HI:`QPW_CMD_OP_LO];
    wire [1:0] cmd_pot = cmd_reg[`QPW_CMD_POT_HI:`QPW_CMD_POT_LO];
    wire [1:0] cmd_slot = cmd_reg[`QPW_CMD_SLOT_HI:`QPW_CMD_SLOT_LO];
    wire [1:0] new_op = shift_reg[`QPW_CMD_OP_HI:`QPW_CMD_OP_LO];
    wire [1:0] new_pot = shift_reg[`QPW_CMD_POT_HI:`QPW_CMD_POT_LO];
    wire [1:0] new_slot = shift_reg[`QPW_CMD_SLOT_HI:`QPW_CMD_SLOT_LO];

    // Slave address is the low three type bits over the pin levels
    wire addr_match = (shift_reg[7:1] == {DEV_TYPE[2:0], addr_pins});

    // Saved slot named by the held and by the fresh command
    wire [3:0] cmd_index = slot_index(cmd_pot, cmd_slot);
    wire [3:0] new_index = slot_index(new_pot, new_slot);

    // Value returned on a read
    wire [5:0] rd_value = (cmd_op == `QPW_OP_SAVED) ? saved_mem[cmd_index]
                                                    : wiper_mem[cmd_pot];

    integer i;

    // ----------------------------------------------------------------
    // Serial slave and register updates
    // ----------------------------------------------------------------
    always @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            st_reg <= ST_IDLE;
            bits_reg <= 4'h0;
            shift_reg <= 8'h00;
            cmd_reg <= 8'h00;
            rw_reg <= 1'b0;
            mack_reg <= 1'b0;
            o_sda_o <= 1'b0;
            o_sda_oe <= 1'b0;
            recall_pend_reg <= 1'b1;
            for (i = 0; i < 4; i = i + 1) begin
                wiper_mem[i] <= 6'h00;
            end
            for (i = 0; i < 16; i = i + 1) begin
                saved_mem[i] <= SAVED_RESET;
            end
        end else begin
            o_sda_o <= 1'b0;
            if (recall_pend_reg) begin
                // First cycle out of reset loads every wiper
                recall_pend_reg <= 1'b0;
                for (i = 0; i < 4; i = i + 1) begin
                    wiper_mem[i] <= saved_mem[slot_index(i[1:0], `QPW_RECALL_SLOT)];
                end
            end else if (bus_start) begin
                st_reg <= ST_ADDR;
                bits_reg <= 4'h0;
                o_sda_oe <= 1'b0;
            end else if (bus_stop) begin
                st_reg <= ST_IDLE;
                o_sda_oe <= 1'b0;
            end else if (scl_rise) begin
                case (st_reg)
                    ST_ADDR, ST_CMD, ST_DATA: begin
                        shift_reg <= {shift_reg[6:0], sda_in};
                        bits_reg <= bits_reg + 4'h1;
                    end
                    ST_READ: begin
                        bits_reg <= bits_reg + 4'h1;
                    end
                    ST_RACK: begin
                        mack_reg <= ~sda_in;
                    end
                    default: begin
                        bits_reg <= bits_reg;
                    end
                endcase
            end else if (scl_fall) begin
                case (st_reg)
                    ST_ADDR: begin
                        if (bits_reg == BYTE_BITS) begin
                            if (addr_match) begin
                                rw_reg <= shift_reg[0];
                                o_sda_oe <= 1'b1;
                                st_reg <= ST_AACK;
                            end else begin
                                st_reg <= ST_IGNORE;
                            end
                        end
                    end
                    ST_AACK: begin
                        bits_reg <= 4'h0;
                        if (rw_reg) begin
                            shift_reg <= {2'b00, rd_value};
                            o_sda_oe <= 1'b1;
                            st_reg <= ST_READ;
                        end else begin
                            o_sda_oe <= 1'b0;
                            st_reg <= ST_CMD;
                        end
                    end
                    ST_CMD: begin
                        if (bits_reg == BYTE_BITS) begin
                            cmd_reg <= shift_reg;
                            o_sda_oe <= 1'b1;
                            st_reg <= ST_CACK;
                            if (new_op == `QPW_OP_RECALL) begin
                                wiper_mem[new_pot] <= saved_mem[new_index];
                            end else if (new_op == `QPW_OP_STORE) begin
                                saved_mem[new_index] <= wiper_mem[new_pot];
                            end
                        end
                    end
                    ST_CACK, ST_DACK: begin
                        o_sda_oe <= 1'b0;
                        bits_reg <= 4'h0;
                        st_reg <= ST_DATA;
                    end
                    ST_DATA: begin
                        if (bits_reg == BYTE_BITS) begin
                            o_sda_oe <= 1'b1;
                            st_reg <= ST_DACK;
                            if (cmd_op == `QPW_OP_SAVED) begin
                                saved_mem[cmd_index] <= shift_reg[5:0];
                            end else if (cmd_op == `QPW_OP_WIPER) begin
                                wiper_mem[cmd_pot] <= shift_reg[5:0];
                            end
                        end
                    end
                    ST_READ: begin
                        if (bits_reg == BYTE_BITS) begin
                            o_sda_oe <= 1'b0;
                            st_reg <= ST_RACK;
                        end else begin
                            shift_reg <= {shift_reg[6:0], 1'b0};
                            o_sda_oe <= ~shift_reg[6];
                        end
                    end
                    ST_RACK: begin
                        bits_reg <= 4'h0;
                        if (mack_reg) begin
                            shift_reg <= {2'b00, rd_value};
                            o_sda_oe <= 1'b1;
                            st_reg <= ST_READ;
                        end else begin
                            st_reg <= ST_IGNORE;
                        end
                    end
                    default: begin
                        o_sda_oe <= 1'b0;
                    end
                endcase
            end
        end
    end

    // ----------------------------------------------------------------
    // Output copies of the wiper registers
    // ----------------------------------------------------------------
    always @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_wiper_tap_select <= 24'h000000;
        end else begin
            o_wiper_tap_select <= {wiper_mem[3], wiper_mem[2], wiper_mem[1], wiper_mem[0]};
        end
    end

    // ----------------------------------------------------------------
    // Transaction status
    // ----------------------------------------------------------------
    // Drops on stop and on a foreign address
    always @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_busy <= 1'b0;
        end else begin
            o_busy <= in_frame(st_reg);
        end
    end

    qpw_tap_decode #(
        .POTS(4),
        .CODE_W(6),
        .TAPS(64)
    ) u_taps (
        .i_clk(i_clk),
        .i_nrst(i_nrst),
        .i_codes(o_wiper_tap_select),
        .o_taps(o_tap_switch)
    );

endmodule // qpw_top

`default_nettype wire

// File: test/qpw_bus_master.sv
// Two-wire bus master model: drives the serial clock and pulls the data line
`default_nettype none
module qpw_bus_master (
    output logic o_scl,
    output logic o_sda_pull,
    input wire logic i_sda
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam realtime QTR = 31.25;
    logic idle = 1'b1;
    initial begin
        o_scl = 1'b1;
        o_sda_pull = 1'b0;
    end
    // One quarter of a 125 ns bit; clock stands high between frames
    task automatic step(input logic c, input logic p);
        o_scl = c;
        o_sda_pull = p;
        #QTR;
    endtask
    task automatic start();
        // Offset keeps pin changes clear of the sampling clock edges
        #0.1;
        if (!idle) begin
            step(1'b0, o_sda_pull);
            step(1'b0, 1'b0);
        end
        step(1'b1, 1'b0);
        step(1'b1, 1'b1);
        idle = 1'b0;
    endtask
    task automatic stop();
        step(1'b0, o_sda_pull);
        step(1'b0, 1'b1);
        step(1'b1, 1'b1);
        step(1'b1, 1'b0);
        idle = 1'b1;
    endtask
    // Data changes only while the clock is low
    task automatic put_bit(input logic b);
        step(1'b0, o_sda_pull);
        step(1'b0, !b);
        step(1'b1, !b);
        step(1'b1, !b);
    endtask
    task automatic get_bit(output logic b);
        step(1'b0, o_sda_pull);
        step(1'b0, 1'b0);
        step(1'b1, 1'b0);
        b = i_sda;
        step(1'b1, 1'b0);
    endtask
    task automatic send(input logic [7:0] d, output logic ack);
        logic b;
        for (int i = 7; i >= 0; i--) put_bit(d[i]);
        get_bit(b);
        ack = !b;
    endtask
    task automatic recv(input logic nack, output logic [7:0] d);
        for (int i = 7; i >= 0; i--) get_bit(d[i]);
        put_bit(nack);
    endtask
endmodule // qpw_bus_master
`default_nettype wire

// File: test/qpw_top_assertions.sv
// Port-level assertions for the quad potentiometer wiper register bank
`default_nettype none
module qpw_top_assertions #(
    parameter logic [5:0] SAVED_RESET = 6'h20
) (
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic i_scl,
    input wire logic i_sda_i,
    input wire logic o_sda_o,
    input wire logic o_sda_oe,
    input wire logic i_addr_pin_bit0,
    input wire logic i_addr_pin_bit1,
    input wire logic i_addr_pin_bit2,
    input wire logic i_addr_pin_bit3,
    input wire logic [23:0] o_wiper_tap_select,
    input wire logic [255:0] o_tap_switch,
    input wire logic o_busy
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_nrst);
    // Cycles since reset release, saturating
    logic [1:0] since_rst;
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            since_rst <= 2'h0;
        end else if (since_rst != 2'h3) begin
            since_rst <= since_rst + 2'h1;
        end
    end
    // ------------
    // Checks
    // ------------
    a_sda_drive_low: assert property (!o_sda_o)
        else $error("data line driven high");
    a_one_tap: assert property (
        $onehot(o_tap_switch[63:0]) && $onehot(o_tap_switch[127:64])
        && $onehot(o_tap_switch[191:128]) && $onehot(o_tap_switch[255:192]))
        else $error("tap select not one-hot");
    a_tap_follows_code: assert property (
        o_tap_switch == {64'h1 << $past(o_wiper_tap_select[23:18]),
        64'h1 << $past(o_wiper_tap_select[17:12]), 64'h1 << $past(o_wiper_tap_select[11:6]),
        64'h1 << $past(o_wiper_tap_select[5:0])})
        else $error("tap decode off its code");
    a_reset_recall: assert property (
        since_rst == 2'h2 |-> ##[0:2] (o_wiper_tap_select == {4{SAVED_RESET}}))
        else $error("slot zero not recalled");
    a_wiper_by_bus: assert property (
        $changed(o_wiper_tap_select) && since_rst == 2'h3 |-> $past(o_busy))
        else $error("wiper changed outside a transaction");
    a_ack_while_busy: assert property ($rose(o_sda_oe) |-> ##[0:3] o_busy)
        else $error("data driven while not addressed");
    a_drive_scl_low: assert property ($changed(o_sda_oe) |-> !i_scl)
        else $error("data changed with clock high");
    a_hold_scl_high: assert property (i_scl ##1 i_scl |-> $stable(o_sda_oe))
        else $error("data not held while clock high");
    a_stop_ends_busy: assert property (
        $rose(i_sda_i) && i_scl && $past(i_scl) |-> ##[1:8] !o_busy)
        else $error("busy stays after stop");
    c_ack: cover property ($rose(o_sda_oe));
    c_bus_write: cover property ($changed(o_wiper_tap_select) && since_rst == 2'h3);
    c_busy_end: cover property ($fell(o_busy));
endmodule // qpw_top_assertions
bind qpw_top qpw_top_assertions #(.SAVED_RESET(SAVED_RESET)) u_checker (
    .i_clk(i_clk), .i_nrst(i_nrst), .i_scl(i_scl), .i_sda_i(i_sda_i), .o_sda_o(o_sda_o),
    .o_sda_oe(o_sda_oe), .i_addr_pin_bit0(i_addr_pin_bit0),
    .i_addr_pin_bit1(i_addr_pin_bit1), .i_addr_pin_bit2(i_addr_pin_bit2),
    .i_addr_pin_bit3(i_addr_pin_bit3), .o_wiper_tap_select(o_wiper_tap_select),
    .o_tap_switch(o_tap_switch), .o_busy(o_busy));
`default_nettype wire

// File: test/testbench.sv
// Self-checking bench for the quad potentiometer wiper register bank
`default_nettype none
`include "qpw_regs.vh"
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [3:0] DEV = `QPW_DEV_TYPE;
    typedef struct packed {logic [1:0] op, pot, slot; logic [5:0] data;
        logic rsaved; logic [5:0] exp_rd, exp_w;} qpw_row_t;
    logic i_clk = 1'b0;
    logic i_nrst = 1'b0;
    logic [3:0] pins = 4'h3;
    logic scl, pull, sda_line, sda_o, sda_oe, busy;
    logic [23:0] wipers;
    logic [255:0] taps;
    int num_errors = 0;
    int samples_checked = 0;
    int cycles = 0;
    qpw_row_t rows [7] = '{
        '{`QPW_OP_WIPER, 2'h1, 2'h0, 6'h15, 1'b0, 6'h15, 6'h15},
        '{`QPW_OP_WIPER, 2'h3, 2'h0, 6'h3f, 1'b0, 6'h3f, 6'h3f},
        '{`QPW_OP_SAVED, 2'h2, 2'h3, 6'h0a, 1'b1, 6'h0a, 6'h20},
        '{`QPW_OP_STORE, 2'h3, 2'h1, 6'h00, 1'b1, 6'h3f, 6'h3f},
        '{`QPW_OP_RECALL, 2'h2, 2'h3, 6'h00, 1'b0, 6'h0a, 6'h0a},
        '{`QPW_OP_WIPER, 2'h0, 2'h0, 6'h00, 1'b0, 6'h00, 6'h00},
        '{`QPW_OP_RECALL, 2'h0, 2'h0, 6'h00, 1'b0, 6'h20, 6'h20}};
    // Open-drain wire with pull-up
    assign sda_line = !((sda_oe && !sda_o) || pull);
    initial begin
        forever #4 i_clk = ~i_clk;
    end
    qpw_top dut (.i_clk(i_clk), .i_nrst(i_nrst), .i_scl(scl), .i_sda_i(sda_line),
        .o_sda_o(sda_o), .o_sda_oe(sda_oe), .i_addr_pin_bit0(pins[0]),
        .i_addr_pin_bit1(pins[1]), .i_addr_pin_bit2(pins[2]), .i_addr_pin_bit3(pins[3]),
        .o_wiper_tap_select(wipers), .o_tap_switch(taps), .o_busy(busy));
    qpw_bus_master m (.o_scl(scl), .o_sda_pull(pull), .i_sda(sda_line));
    task automatic chk(input string name, input logic [63:0] exp, input logic [63:0] got);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic wait_clk(input int n);
        repeat (n) @(posedge i_clk);
    endtask
    function automatic logic [7:0] dev_addr(input logic rd);
        return {DEV[2:0], pins, rd};
    endfunction
    task automatic wr(input logic [7:0] cmd, input logic [7:0] d, input logic with_data);
        logic ack;
        m.start();
        m.send(dev_addr(1'b0), ack);
        chk("addr_ack", 1, ack);
        chk("busy", 1, busy);
        m.send(cmd, ack);
        chk("cmd_ack", 1, ack);
        if (with_data) begin
            m.send(d, ack);
            chk("data_ack", 1, ack);
        end
        m.stop();
        wait_clk(8);
        chk("busy_end", 0, busy);
    endtask
    task automatic rd(input logic [7:0] cmd, output logic [7:0] v);
        logic ack;
        m.start();
        m.send(dev_addr(1'b0), ack);
        m.send(cmd, ack);
        m.start();
        m.send(dev_addr(1'b1), ack);
        chk("rd_addr_ack", 1, ack);
        m.recv(1'b1, v);
        m.stop();
        wait_clk(8);
    endtask
    task automatic check_recall();
        chk("recall", {4{`QPW_SAVED_RESET}}, wipers);
        for (int p = 0; p < 4; p++) begin
            chk("recall_tap", 64'h1 << `QPW_SAVED_RESET, taps[p*64 +: 64]);
        end
    endtask
    task automatic conclude();
        $display("Checks %0d, mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 30000) begin
            num_errors++;
            conclude();
        end
    end
    initial begin
        qpw_row_t r;
        logic [7:0] v;
        logic ack;
        wait_clk(20);
        chk("oe_in_reset", 0, sda_oe);
        i_nrst <= 1'b1;
        wait_clk(6);
        check_recall();
        foreach (rows[i]) begin
            r = rows[i];
            wr({r.op, r.pot, r.slot, 2'b00}, {2'b00, r.data}, !r.op[1]);
            rd({1'b0, r.rsaved, r.pot, r.slot, 2'b00}, v);
            chk("read_back", {2'b00, r.exp_rd}, v);
            chk("wiper", r.exp_w, wipers[r.pot*6 +: 6]);
            chk("taps", 64'h1 << r.exp_w, taps[r.pot*64 +: 64]);
        end
        // Reversed pin order must not be answered
        m.start();
        m.send({DEV[2:0], pins[0], pins[1], pins[2], pins[3], 1'b0}, ack);
        chk("foreign_ack", 0, ack);
        m.send(8'h10, ack);
        chk("foreign_cmd", 0, ack);
        m.stop();
        wait_clk(8);
        chk("foreign_busy", 0, busy);
        chk("foreign_wiper", 6'h15, wipers[11:6]);
        // Second data byte to the same wiper, then a read acked once
        m.start();
        m.send(dev_addr(1'b0), ack);
        m.send(8'h10, ack);
        m.send(8'h07, ack);
        m.send(8'h15, ack);
        chk("second_data_ack", 1, ack);
        m.start();
        m.send(dev_addr(1'b1), ack);
        m.recv(1'b0, v);
        chk("read_first", 8'h15, v);
        m.recv(1'b1, v);
        chk("read_repeat", 8'h15, v);
        m.stop();
        wait_clk(8);
        chk("frame_wiper", 6'h15, wipers[11:6]);
        chk("frame_busy", 0, busy);
        pins <= 4'hc;
        wait_clk(6);
        wr(8'h10, 8'h2a, 1'b1);
        chk("new_pins", 6'h2a, wipers[11:6]);
        i_nrst <= 1'b0;
        wait_clk(3);
        chk("rst_wipers", 24'h000000, wipers);
        chk("rst_busy", 0, busy);
        i_nrst <= 1'b1;
        wait_clk(6);
        check_recall();
        conclude();
    end
endmodule // testbench
`default_nettype wire
